// ===== verilog/timer_event_counter_config.sv
// Configuration registers and control decode of a 16-bit timer/event counter.
// Assumes an AXI4-Lite master and a counting datapath fed by its outputs.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Software trigger acts only in trigger pulse or one-shot mode.
// - Event count mode counts event input, ignoring external clock enable.
// - Output pin follows output level bit even when disabled and stopped.
// - Capture only in free-running and pulse width measurement modes.
// - Event edge select applies only with external clock enable or mode 001.
// - Trigger edge select applies only in modes 010 and 011.
module timer_event_counter_config
   import timer_cfg_pkg::*;
(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic [7:0] s_axi_awaddr,
   input  wire logic       s_axi_awvalid,
   output logic            s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0] s_axi_wstrb,
   input  wire logic       s_axi_wvalid,
   output logic            s_axi_wready,
   output logic [1:0]      s_axi_bresp,
   output logic            s_axi_bvalid,
   input  wire logic       s_axi_bready,
   input  wire logic [7:0] s_axi_araddr,
   input  wire logic       s_axi_arvalid,
   output logic            s_axi_arready,
   output logic [31:0]     s_axi_rdata,
   output logic [1:0]      s_axi_rresp,
   output logic            s_axi_rvalid,
   input  wire logic       s_axi_rready,
   input  wire logic       event_in,
   output logic [1:0]      timer_output_pin,
   output timer_cfg_s      cfg_active,
   output logic            software_trigger_pulse,
   output logic            event_count_select,
   output logic            capture_allowed,
   output logic [1:0]      event_edge_active,
   output logic [1:0]      trigger_edge_active
);

   timer_cfg_s cfg_q;
   logic [7:0] aw_addr_q;
   logic       aw_have_q;
   logic [7:0] w_data_q;
   logic       w_strb_q;
   logic       w_have_q;
   logic       do_write;

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a <= OFS_STATUS) && (a[1:0] == 2'h0);
   endfunction

   // Write address and data may arrive in either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_q     <= 1'b0;
         w_have_q      <= 1'b0;
         aw_addr_q     <= 8'h00;
         w_data_q      <= 8'h00;
         w_strb_q      <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= AXI_OKAY;
      end
      else
      begin
         s_axi_awready <= !aw_have_q && !s_axi_awready && !s_axi_bvalid
                          && s_axi_awvalid;
         s_axi_wready  <= !w_have_q && !s_axi_wready && !s_axi_bvalid
                          && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata[7:0];
            w_strb_q <= s_axi_wstrb[0];
         end
         if (do_write)
         begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(aw_addr_q) ? AXI_OKAY : AXI_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;

   // Hardware takes writes whether running or stopped; the stop-before-change discipline
   // belongs to software, so no write is refused for a running count
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         cfg_q <= '0;
      else if (do_write && w_strb_q)
      begin
         case (aw_addr_q)
            OFS_CTL_FIRST:
            begin
               cfg_q.count_enable          <= w_data_q[CE_POS];
               cfg_q.clock_prescale_select <= w_data_q[2:0];
            end
            OFS_CTL_SECOND:
            begin
               cfg_q.tandem_sync           <= w_data_q[TSYE_POS];
               cfg_q.external_clock_enable <= w_data_q[EEE_POS];
               cfg_q.operating_mode_field  <= w_data_q[2:0];
            end
            OFS_OUT_CTL:
            begin
               cfg_q.output_level  <= {w_data_q[3], w_data_q[1]};
               cfg_q.output_enable <= {w_data_q[2], w_data_q[0]};
            end
            OFS_CAP_CTL:
               cfg_q.capture_edge_select <= w_data_q[3:0];
            OFS_EDGE_CTL:
            begin
               cfg_q.trigger_edge_select <= w_data_q[1:0];
               cfg_q.event_edge_select   <= w_data_q[3:2];
            end
            OFS_OPTION:
               cfg_q.capture_compare_select <= w_data_q[5:4];
            default:
               cfg_q <= cfg_q;
         endcase
      end
   end

   // Trigger is a one-cycle pulse, never stored
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         software_trigger_pulse <= 1'b0;
      else
         software_trigger_pulse <= do_write && w_strb_q
            && aw_addr_q == OFS_CTL_SECOND && w_data_q[EST_POS]
            && (cfg_q.operating_mode_field == MODE_TRIG_PULSE
             || cfg_q.operating_mode_field == MODE_ONE_SHOT);
   end

   // Decoded controls for the counting datapath
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cfg_active          <= '0;
         timer_output_pin    <= 2'h0;
         event_count_select  <= 1'b0;
         capture_allowed     <= 1'b0;
         event_edge_active   <= 2'h0;
         trigger_edge_active <= 2'h0;
      end
      else
      begin
         cfg_active <= cfg_q;
         // Level bit drives the pin even when stopped and disabled
         timer_output_pin <= cfg_q.output_level;
         event_count_select <= cfg_q.external_clock_enable
            || cfg_q.operating_mode_field == MODE_EVENT_CNT;
         capture_allowed <= cfg_q.count_enable
            && (cfg_q.operating_mode_field == MODE_FREE_RUN
             || cfg_q.operating_mode_field == MODE_PULSE_MEAS);
         event_edge_active <= (cfg_q.external_clock_enable
            || cfg_q.operating_mode_field == MODE_EVENT_CNT)
            ? cfg_q.event_edge_select : 2'h0;
         trigger_edge_active <=
            (cfg_q.operating_mode_field == MODE_TRIG_PULSE
          || cfg_q.operating_mode_field == MODE_ONE_SHOT)
            ? cfg_q.trigger_edge_select : 2'h0;
      end
   end

   // Read channel, one cycle to accept, answer the next
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= AXI_OKAY;
      end
      else
      begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= mapped(s_axi_araddr) ? AXI_OKAY : AXI_SLVERR;
            case (s_axi_araddr)
               OFS_CTL_FIRST:  s_axi_rdata <= {24'h0, cfg_q.count_enable,
                                  4'h0, cfg_q.clock_prescale_select};
               OFS_CTL_SECOND: s_axi_rdata <= {24'h0, cfg_q.tandem_sync,
                                  1'b0, cfg_q.external_clock_enable, 2'h0,
                                  cfg_q.operating_mode_field};
               OFS_OUT_CTL:    s_axi_rdata <= {28'h0,
                                  cfg_q.output_level[1],
                                  cfg_q.output_enable[1],
                                  cfg_q.output_level[0],
                                  cfg_q.output_enable[0]};
               OFS_CAP_CTL:    s_axi_rdata <= {28'h0,
                                  cfg_q.capture_edge_select};
               OFS_EDGE_CTL:   s_axi_rdata <= {28'h0,
                                  cfg_q.event_edge_select,
                                  cfg_q.trigger_edge_select};
               OFS_OPTION:     s_axi_rdata <= {26'h0,
                                  cfg_q.capture_compare_select, 4'h0};
               OFS_STATUS:     s_axi_rdata <= {28'h0, event_in,
                                  capture_allowed, event_count_select,
                                  cfg_q.count_enable};
               default:        s_axi_rdata <= 32'h0000_0000;
            endcase
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

endmodule // timer_event_counter_config

`default_nettype wire

// ===== pkg/timer_cfg_pkg.sv
// Package for the timer configuration block: register offsets, field
// positions, reset values, mode codes and bus types.
// Assumes an AXI4-Lite master with 32-bit data.
package timer_cfg_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CTL_FIRST  = 8'h00;
   localparam logic [7:0] OFS_CTL_SECOND = 8'h04;
   localparam logic [7:0] OFS_OUT_CTL    = 8'h08;
   localparam logic [7:0] OFS_CAP_CTL    = 8'h0C;
   localparam logic [7:0] OFS_EDGE_CTL   = 8'h10;
   localparam logic [7:0] OFS_OPTION     = 8'h14;
   localparam logic [7:0] OFS_STATUS     = 8'h18;

   // Field positions
   localparam int CE_POS     = 7;   // count enable in first control
   localparam int EST_POS    = 6;   // software trigger in second control
   localparam int EEE_POS    = 5;   // external clock enable
   localparam int TSYE_POS   = 7;   // tandem sync enable

   localparam logic [1:0] AXI_OKAY   = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;

   // Operating mode codes
   localparam logic [2:0] MODE_INTERVAL   = 3'h0;
   localparam logic [2:0] MODE_EVENT_CNT  = 3'h1;
   localparam logic [2:0] MODE_TRIG_PULSE = 3'h2;
   localparam logic [2:0] MODE_ONE_SHOT   = 3'h3;
   localparam logic [2:0] MODE_PWM        = 3'h4;
   localparam logic [2:0] MODE_FREE_RUN   = 3'h5;
   localparam logic [2:0] MODE_PULSE_MEAS = 3'h6;

   localparam logic [7:0] CFG_RESET = 8'h00;

   typedef struct packed {
      logic       count_enable;
      logic [2:0] clock_prescale_select;
      logic       tandem_sync;
      logic       external_clock_enable;
      logic [2:0] operating_mode_field;
      logic [1:0] output_level;
      logic [1:0] output_enable;
      logic [3:0] capture_edge_select;
      logic [1:0] event_edge_select;
      logic [1:0] trigger_edge_select;
      logic [1:0] capture_compare_select;
   } timer_cfg_s;
endpackage

// ===== tb/timer_cfg_assertions.sv
// Concurrent checks on the timer configuration block outputs.
// Assumes it is bound into timer_event_counter_config.
`timescale 1ns/1ps
`default_nettype none
module timer_cfg_assertions
   import timer_cfg_pkg::*;
(
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic       s_axi_bvalid,
   input wire logic       s_axi_bready,
   input wire logic [1:0] timer_output_pin,
   input wire timer_cfg_s cfg_active,
   input wire logic       software_trigger_pulse,
   input wire logic       event_count_select,
   input wire logic       capture_allowed,
   input wire logic [1:0] event_edge_active,
   input wire logic [1:0] trigger_edge_active
);
   logic [2:0] md;
   logic       tm;
   logic       es;
   logic       cp;
   assign md = cfg_active.operating_mode_field;
   assign tm = md == MODE_TRIG_PULSE || md == MODE_ONE_SHOT;
   assign es = cfg_active.external_clock_enable || md == MODE_EVENT_CNT;
   assign cp = cfg_active.count_enable
      && (md == MODE_FREE_RUN || md == MODE_PULSE_MEAS);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_PIN: assert property (timer_output_pin == cfg_active.output_level)
      else $error("pin level mismatch");
   AST_EVSEL: assert property (event_count_select == es)
      else $error("event select mismatch");
   AST_EVEDGE: assert property (event_edge_active ==
      (es ? cfg_active.event_edge_select : 2'h0)) else $error("event edge");
   AST_TREDGE: assert property (trigger_edge_active ==
      (tm ? cfg_active.trigger_edge_select : 2'h0)) else $error("trig edge");
   AST_CAP: assert property (capture_allowed == cp)
      else $error("capture");
   AST_TRIG: assert property (software_trigger_pulse |-> $past(tm))
      else $error("trigger in wrong mode");
   AST_TRIG_ONE: assert property (software_trigger_pulse |=>
      !software_trigger_pulse) else $error("trigger pulse too long");
   AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid) else $error("write response dropped");
   AST_BDONE: assert property (s_axi_bvalid && s_axi_bready |=>
      !s_axi_bvalid) else $error("write response not released");
endmodule // timer_cfg_assertions
bind timer_event_counter_config timer_cfg_assertions chk (.aclk, .aresetn,
   .s_axi_bvalid, .s_axi_bready, .timer_output_pin, .cfg_active,
   .software_trigger_pulse, .event_count_select, .capture_allowed,
   .event_edge_active, .trigger_edge_active);
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the timer configuration block.
// Assumes the bench is the only AXI4-Lite master.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import timer_cfg_pkg::*;
   logic        aclk = 1'b0, aresetn = 1'b0, event_in = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'h1;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, timer_output_pin;
   logic [1:0]  event_edge_active, trigger_edge_active;
   logic        software_trigger_pulse, event_count_select, capture_allowed;
   timer_cfg_s  cfg_active;
   int          miscompares = 0, compares = 0, pulses = 0;
   timer_event_counter_config dut (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .event_in,
      .timer_output_pin, .cfg_active, .software_trigger_pulse,
      .event_count_select, .capture_allowed, .event_edge_active,
      .trigger_edge_active);
   always #12.5 aclk = ~aclk;
   always @(posedge aclk) if (software_trigger_pulse === 1'b1) pulses++;
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Bounded waits: a hung handshake ends the run as a mismatch
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 40 && s_axi_bvalid !== 1'b1; n++)
      begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1)
            s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      check(32'(s_axi_bresp), 32'(er));
      if (n == 40)
      begin
         miscompares++;
         test_done();
      end
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 40 && s_axi_rvalid !== 1'b1; n++)
      begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1)
            s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      check(s_axi_rdata, ed);
      check(32'(s_axi_rresp), 32'(er));
      if (n == 40)
      begin
         miscompares++;
         test_done();
      end
      @(posedge aclk);
   endtask
   task automatic outs(input logic es, input logic ts, input logic cp);
      repeat (2) @(posedge aclk);
      check(32'(event_count_select), 32'(es));
      check(32'(event_edge_active), es ? 32'h3 : 32'h0);
      check(32'(trigger_edge_active), ts ? 32'h2 : 32'h0);
      check(32'(capture_allowed), 32'(cp));
   endtask
   task automatic modes;
      int ep;
      ep = 0;
      for (int i = 0; i < 7; i++)
      begin
         wr(OFS_CTL_FIRST, 32'h0, AXI_OKAY);
         wr(OFS_CTL_SECOND, 32'(i), AXI_OKAY);
         wr(OFS_EDGE_CTL, 32'hE, AXI_OKAY);
         wr(OFS_CTL_SECOND, 32'h40 | 32'(i), AXI_OKAY);
         wr(OFS_CTL_FIRST, 32'h80, AXI_OKAY);
         ep += (i == 2 || i == 3) ? 1 : 0;
         outs(i == 1, i == 2 || i == 3, i == 5 || i == 6);
         check(32'(pulses), 32'(ep));
         rd(OFS_STATUS, {29'h0, i == 5 || i == 6, i == 1, 1'b1}, AXI_OKAY);
      end
      // External clock enable alone also selects the event edge
      event_in <= 1'b1;
      wr(OFS_CTL_FIRST, 32'h0, AXI_OKAY);
      wr(OFS_CTL_SECOND, 32'h20, AXI_OKAY);
      outs(1'b1, 1'b0, 1'b0);
      rd(OFS_STATUS, 32'hA, AXI_OKAY);
   endtask
   task automatic pins;
      for (int i = 0; i < 4; i++)
      begin
         wr(OFS_OUT_CTL, {28'h0, i[1], 1'b0, i[0], 1'b0}, AXI_OKAY);
         repeat (2) @(posedge aclk);
         check(32'(timer_output_pin), 32'(i));
         rd(OFS_OUT_CTL, {28'h0, i[1], 1'b0, i[0], 1'b0}, AXI_OKAY);
      end
   endtask
   task automatic start_with_prescale;
      wr(OFS_OPTION, 32'h30, AXI_OKAY);
      wr(OFS_CTL_FIRST, 32'h85, AXI_OKAY);
      repeat (2) @(posedge aclk);
      check(32'(cfg_active.clock_prescale_select), 32'h5);
      check(32'(cfg_active.capture_compare_select), 32'h3);
      rd(OFS_CTL_FIRST, 32'h85, AXI_OKAY);
      rd(8'h40, 32'h0, AXI_SLVERR);
      wr(8'h40, 32'h1, AXI_SLVERR);
   endtask
   // Fields written while stopped; a lane 0 strobe off stores nothing
   task automatic stopped_fields;
      wr(OFS_CAP_CTL, 32'h9, AXI_OKAY);
      wr(OFS_OUT_CTL, 32'h7, AXI_OKAY);
      repeat (2) @(posedge aclk);
      check(32'(cfg_active.capture_edge_select), 32'h9);
      check(32'(cfg_active.output_enable), 32'h3);
      check(32'(timer_output_pin), 32'h1);
      rd(OFS_OUT_CTL, 32'h7, AXI_OKAY);
      s_axi_wstrb <= 4'hE;
      wr(OFS_CAP_CTL, 32'h6, AXI_OKAY);
      s_axi_wstrb <= 4'h1;
      rd(OFS_CAP_CTL, 32'h9, AXI_OKAY);
   endtask
   // Reset in mid-run must clear the capture edge and first control fields and the pin
   task automatic mid_reset;
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      check(32'(timer_output_pin), 32'h0);
      rd(OFS_CAP_CTL, 32'h0, AXI_OKAY);
      rd(OFS_CTL_FIRST, 32'h0, AXI_OKAY);
   endtask
   initial
   begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(OFS_STATUS, 32'h0, AXI_OKAY);
      modes();
      pins();
      stopped_fields();
      start_with_prescale();
      mid_reset();
      test_done();
   end
endmodule // testbench
`default_nettype wire
